// file: include/yfe_pkg.sv
// Shared constants for the luma frequency and edge front end
//
// Functional notes
// - 24-bit word: motion, chroma, luma bytes.
// - Source may tie unused bytes constant.
// - Motion byte is luma change magnitude.
// - 4:2:0 chroma flag alternates; honoured when set.
// - Chroma flag changes only outside active video.
// - 4:2:2 holds chroma flag high.
// - Same byte timing for both formats.
// - Frequency results from luma only, per pixel.
// - Low pass: 7-tap FIR -1,0,9,16,9,0,-1.
// - High pass is luma minus low pass.
// - High pass gain 1/2/4/8, clamp 0..255.
// - Four luma Sobel filters, four orientations.
// - Each edge gain 0,1,2,4 or 8.
// - Edge content is sum of gained filters.
// - 3x3 windows from two-line buffer.
// - Parallel pipelines forwarded to downstream stages.
package yfe_pkg;
  localparam int YFE_WORD_W = 24;
  localparam int YFE_LUMA_LSB = 0;
  localparam int YFE_CHROMA_LSB = 8;
  localparam int YFE_MOTION_LSB = 16;
  localparam int YFE_MAX_WIDTH = 1920;

  // Software register byte addresses
  localparam logic [7:0] YFE_REG_HF_GAIN = 8'h00;
  localparam logic [7:0] YFE_REG_EDGE_GAIN = 8'h04;
  localparam logic [7:0] YFE_REG_STATUS = 8'h08;

  // Reset values: unity gain everywhere
  localparam logic [1:0] YFE_HF_GAIN_RST = 2'h0;
  localparam logic [11:0] YFE_EDGE_GAIN_RST = 12'h249;

  // Edge gain code field width and codes 0..4 -> x0,x1,x2,x4,x8
  localparam int YFE_EG_W = 3;
  localparam logic [2:0] YFE_EG_MAX = 3'h4;

  // Filter figures
  localparam int YFE_LP_TAPS = 7;
  localparam int YFE_LP_SHIFT = 5;
  localparam int YFE_LAT = 2;
  localparam int YFE_CM_DLY = 4;
endpackage

// file: include/yfe_link_if.sv
// Pixel link between the video source and the front end
`timescale 1ns/1ps
interface yfe_link_if;
  logic [23:0] pixel_motion_word;
  logic active_video;
  logic chroma_valid;

  modport src (
    output pixel_motion_word,
    output active_video,
    output chroma_valid
  );

  modport dev (
    input pixel_motion_word,
    input active_video,
    input chroma_valid
  );
endinterface

// file: hdl/yfe_source.sv
// Video source end: formats user pixels onto the link
`timescale 1ns/1ps
module yfe_source
  import yfe_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic fmt_420,
  input wire logic use_motion,
  input wire logic user_active,
  input wire logic [7:0] user_luma,
  input wire logic [7:0] user_chroma,
  input wire logic [7:0] user_motion,
  yfe_link_if.src link
);
  logic [23:0] word;
  logic active;
  logic chroma_flag;
  logic [23:0] next_word;
  logic next_active;
  logic next_chroma_flag;

  always_comb begin
    // Same word layout and latency for both formats
    next_word = {(use_motion ? user_motion : 8'h00), user_chroma,
                 user_luma};
    next_active = user_active;
    next_chroma_flag = chroma_flag;
    // Flag may only move in a cycle whose output is blanked
    if (!user_active) begin
      if (!fmt_420) begin
        next_chroma_flag = 1'b1;
      end else if (active) begin
        next_chroma_flag = ~chroma_flag;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      word <= 24'h000000;
      active <= 1'b0;
      chroma_flag <= 1'b1;
    end else begin
      word <= next_word;
      active <= next_active;
      chroma_flag <= next_chroma_flag;
    end
  end

  assign link.pixel_motion_word = word;
  assign link.active_video = active;
  assign link.chroma_valid = chroma_flag;
endmodule

// file: hdl/yfe_front_end.sv
// Luma frequency and edge front end with software gain registers
`timescale 1ns/1ps
module yfe_front_end
  import yfe_pkg::*;
#(
  parameter int MAX_WIDTH = YFE_MAX_WIDTH
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  yfe_link_if.dev link,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic res_valid,
  output logic [7:0] lf_out,
  output logic [7:0] hf_out,
  output logic [7:0] edge_out,
  output logic [7:0] chroma_out,
  output logic chroma_ok,
  output logic [7:0] motion_out
);
  localparam int XW = $clog2(MAX_WIDTH);

  function automatic logic signed [11:0] ext(input logic [7:0] v);
    return {4'h0, v};
  endfunction

  function automatic logic [10:0] mag(input logic signed [11:0] v);
    logic signed [11:0] n;
    n = -v;
    return v[11] ? n[10:0] : v[10:0];
  endfunction

  // Codes above x8 are treated as off
  function automatic logic [13:0] edge_gain(input logic [10:0] v,
                                            input logic [2:0] code);
    logic [13:0] r;
    r = 14'h0000;
    if (code != 3'h0 && code <= YFE_EG_MAX) begin
      r = {3'h0, v} << (code - 3'h1);
    end
    return r;
  endfunction

  // Software registers
  logic [1:0] hf_gain;
  logic [11:0] edge_gains;
  logic [15:0] line_cnt;
  logic [15:0] last_width;
  logic [1:0] next_hf_gain;
  logic [11:0] next_edge_gains;
  logic [31:0] next_rdata;

  always_comb begin
    next_hf_gain = hf_gain;
    next_edge_gains = edge_gains;
    next_rdata = 32'h00000000;
    if (reg_wr && reg_addr == YFE_REG_HF_GAIN) begin
      next_hf_gain = reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == YFE_REG_EDGE_GAIN) begin
      next_edge_gains = reg_wdata[11:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        YFE_REG_HF_GAIN: next_rdata = {30'h0, hf_gain};
        YFE_REG_EDGE_GAIN: next_rdata = {20'h0, edge_gains};
        YFE_REG_STATUS: next_rdata = {line_cnt, last_width};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hf_gain <= YFE_HF_GAIN_RST;
      edge_gains <= YFE_EDGE_GAIN_RST;
      reg_rdata <= 32'h00000000;
    end else begin
      hf_gain <= next_hf_gain;
      edge_gains <= next_edge_gains;
      reg_rdata <= next_rdata;
    end
  end

  // Input unpacking; unused bytes need no special handling
  logic [7:0] in_luma;
  logic [7:0] in_chroma;
  logic [7:0] in_motion;
  logic in_act;
  assign in_luma = link.pixel_motion_word[YFE_LUMA_LSB +: 8];
  assign in_chroma = link.pixel_motion_word[YFE_CHROMA_LSB +: 8];
  assign in_motion = link.pixel_motion_word[YFE_MOTION_LSB +: 8];
  assign in_act = link.active_video;

  // Column counter and line statistics
  logic [15:0] col;
  logic act_d;
  logic [15:0] next_col;
  logic [15:0] next_line_cnt;
  logic [15:0] next_last_width;
  logic col_ok;
  logic [XW-1:0] idx;
  assign col_ok = col < 16'(MAX_WIDTH);
  assign idx = col[XW-1:0];

  always_comb begin
    next_col = in_act ? col + 16'h0001 : 16'h0000;
    next_line_cnt = line_cnt;
    next_last_width = last_width;
    if (act_d && !in_act) begin
      next_line_cnt = line_cnt + 16'h0001;
      next_last_width = col;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      col <= 16'h0000;
      act_d <= 1'b0;
      line_cnt <= 16'h0000;
      last_width <= 16'h0000;
    end else begin
      col <= next_col;
      act_d <= in_act;
      line_cnt <= next_line_cnt;
      last_width <= next_last_width;
    end
  end

  // Two line buffer; pixels past the maximum width are not stored
  logic [7:0] line_a [MAX_WIDTH];
  logic [7:0] line_b [MAX_WIDTH];
  logic [7:0] up1;
  logic [7:0] up2;
  assign up1 = col_ok ? line_a[idx] : 8'h00;
  assign up2 = col_ok ? line_b[idx] : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (in_act && col_ok) begin
      line_b[idx] <= line_a[idx];
      line_a[idx] <= in_luma;
    end
  end

  // Stage one: tap line and 3x3 window, shifted per active pixel
  logic [7:0] tap [YFE_LP_TAPS];
  logic [7:0] win [3][3];
  logic [16:0] cm [YFE_CM_DLY];
  logic s1_valid;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s1_valid <= 1'b0;
      for (int i = 0; i < YFE_LP_TAPS; i++) begin
        tap[i] <= 8'h00;
      end
      for (int i = 0; i < YFE_CM_DLY; i++) begin
        cm[i] <= 17'h00000;
      end
      for (int r = 0; r < 3; r++) begin
        for (int c = 0; c < 3; c++) begin
          win[r][c] <= 8'h00;
        end
      end
    end else begin
      s1_valid <= in_act;
      if (in_act) begin
        for (int i = 0; i < YFE_LP_TAPS - 1; i++) begin
          tap[i] <= tap[i+1];
        end
        tap[YFE_LP_TAPS-1] <= in_luma;
        // Chroma counts only on lines flagged valid
        cm[YFE_CM_DLY-1] <= {link.chroma_valid, in_chroma,
                             in_motion};
        for (int i = 0; i < YFE_CM_DLY - 1; i++) begin
          cm[i] <= cm[i+1];
        end
        for (int r = 0; r < 3; r++) begin
          win[r][0] <= win[r][1];
          win[r][1] <= win[r][2];
        end
        win[0][2] <= up2;
        win[1][2] <= up1;
        win[2][2] <= in_luma;
      end
    end
  end

  // Frequency pipeline
  logic signed [15:0] lf_sum;
  logic signed [15:0] lf_div;
  logic [7:0] lf_sat;
  logic signed [9:0] hf_diff;
  logic signed [12:0] hf_gained;
  logic [7:0] hf_sat;

  always_comb begin
    lf_sum = $signed({8'h00, tap[2]}) * 16'sd9
           + $signed({8'h00, tap[4]}) * 16'sd9
           + ($signed({8'h00, tap[3]}) <<< 4)
           - $signed({8'h00, tap[0]})
           - $signed({8'h00, tap[6]});
    lf_div = lf_sum >>> YFE_LP_SHIFT;
    if (lf_div < 16'sd0) begin
      lf_sat = 8'h00;
    end else if (lf_div > 16'sd255) begin
      lf_sat = 8'hff;
    end else begin
      lf_sat = lf_div[7:0];
    end
    hf_diff = $signed({2'h0, tap[3]}) - $signed({2'h0, lf_sat});
    hf_gained = {{3{hf_diff[9]}}, hf_diff} <<< hf_gain;
    if (hf_gained < 13'sd0) begin
      hf_sat = 8'h00;
    end else if (hf_gained > 13'sd255) begin
      hf_sat = 8'hff;
    end else begin
      hf_sat = hf_gained[7:0];
    end
  end

  // Edge pipeline, window centre is win[1][1]
  logic signed [11:0] sob [4];
  logic [15:0] edge_sum;
  logic [7:0] edge_sat;

  always_comb begin
    sob[0] = ext(win[0][0]) + (ext(win[0][1]) <<< 1) + ext(win[0][2])
           - ext(win[2][0]) - (ext(win[2][1]) <<< 1)
           - ext(win[2][2]);
    sob[1] = ext(win[0][0]) + (ext(win[1][0]) <<< 1) + ext(win[2][0])
           - ext(win[0][2]) - (ext(win[1][2]) <<< 1) - ext(win[2][2]);
    sob[2] = ext(win[0][1]) + (ext(win[0][0]) <<< 1) + ext(win[1][0])
           - ext(win[1][2]) - (ext(win[2][2]) <<< 1) - ext(win[2][1]);
    sob[3] = ext(win[0][1]) + (ext(win[0][2]) <<< 1) + ext(win[1][2])
           - ext(win[1][0]) - (ext(win[2][0]) <<< 1) - ext(win[2][1]);
    edge_sum = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      edge_sum = edge_sum + {2'h0, edge_gain(mag(sob[k]),
                 edge_gains[k*YFE_EG_W +: YFE_EG_W])};
    end
    edge_sat = (edge_sum > 16'h00ff) ? 8'hff : edge_sum[7:0];
  end

  // Output stage: all results leave together
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      res_valid <= 1'b0;
      lf_out <= 8'h00;
      hf_out <= 8'h00;
      edge_out <= 8'h00;
      chroma_out <= 8'h00;
      chroma_ok <= 1'b0;
      motion_out <= 8'h00;
    end else begin
      res_valid <= s1_valid;
      lf_out <= lf_sat;
      hf_out <= hf_sat;
      edge_out <= edge_sat;
      chroma_out <= cm[0][15:8];
      chroma_ok <= cm[0][16] & s1_valid;
      motion_out <= cm[0][7:0];
    end
  end
endmodule

// file: sim/yfe_link_assertions.sv
// Checker on the pixel link between source and front end
`timescale 1ns/1ps
module yfe_link_assertions (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic fmt_420,
  input wire logic use_motion,
  input wire logic user_active,
  input wire logic [7:0] user_luma,
  input wire logic [7:0] user_chroma,
  input wire logic [7:0] user_motion,
  input wire logic [23:0] pixel_motion_word,
  input wire logic active_video,
  input wire logic chroma_valid,
  input wire logic res_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_lat; 1 |=> active_video == $past(user_active); endproperty
  a_lat: assert property (p_lat) else $error("link active late");
  property p_luma; user_active |=> pixel_motion_word[7:0] == $past(user_luma);
  endproperty
  a_luma: assert property (p_luma) else $error("luma byte wrong");
  property p_chr; user_active |=>
    pixel_motion_word[15:8] == $past(user_chroma); endproperty
  a_chr: assert property (p_chr) else $error("chroma byte wrong");
  property p_mot; user_active |=> pixel_motion_word[23:16] ==
    ($past(use_motion) ? $past(user_motion) : 8'h00); endproperty
  a_mot: assert property (p_mot) else $error("motion byte wrong");
  property p_hold; active_video && $past(active_video) |->
    $stable(chroma_valid); endproperty
  a_hold: assert property (p_hold) else $error("flag moved in line");
  property p_422; !fmt_420 && !active_video |=> chroma_valid; endproperty
  a_422: assert property (p_422) else $error("flag low in 4:2:2");
  property p_tog; fmt_420 && $fell(active_video) |->
    ##[0:1] chroma_valid != $past(chroma_valid); endproperty
  a_tog: assert property (p_tog) else $error("flag did not toggle");
  property p_res; res_valid == $past(active_video, 2); endproperty
  a_res: assert property (p_res) else $error("result not 2 late");
endmodule

// file: sim/tb_top.sv
// Self-checking bench: source and front end joined by the link
`timescale 1ns/1ps
module tb_top;
  import yfe_pkg::*;
  localparam int W = 16;
  localparam logic [11:0] EGT [5] = '{12'h004, 12'h018, 12'h080, 12'h200,
    12'hfa8};
  logic clk_sys = 0, rst_b = 0, fmt_420 = 1, use_motion = 1;
  logic user_active = 0, reg_wr = 0, reg_rd = 0, res_valid, chroma_ok;
  logic [7:0] user_luma = 0, user_chroma = 0, user_motion = 0, reg_addr = 0;
  logic [7:0] lf_out, hf_out, edge_out, chroma_out, motion_out;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [1:0] hs = 0;
  logic [11:0] eg = 12'h249;
  logic cf = 1;
  logic flg [4096];
  int luma [4096], chr [4096], mot [4096];
  int mismatches = 0, checks_done = 0, np = 0, no = 0, lines = 0;
  yfe_link_if link_if ();
  yfe_source yfe_source_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .fmt_420(fmt_420), .use_motion(use_motion), .user_active(user_active),
    .user_luma(user_luma), .user_chroma(user_chroma),
    .user_motion(user_motion), .link(link_if));
  yfe_front_end #(.MAX_WIDTH(W)) yfe_front_end_inst (.clk_sys(clk_sys),
    .rst_b(rst_b), .link(link_if), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .res_valid(res_valid), .lf_out(lf_out),
    .hf_out(hf_out), .edge_out(edge_out), .chroma_out(chroma_out),
    .chroma_ok(chroma_ok), .motion_out(motion_out));
  yfe_link_assertions chk_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .fmt_420(fmt_420), .use_motion(use_motion), .user_active(user_active),
    .user_luma(user_luma), .user_chroma(user_chroma),
    .user_motion(user_motion), .pixel_motion_word(link_if.pixel_motion_word),
    .active_video(link_if.active_video),
    .chroma_valid(link_if.chroma_valid), .res_valid(res_valid));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  function automatic int sat(int v);
    return v < 0 ? 0 : (v > 255 ? 255 : v);
  endfunction
  function automatic int lfm(int n);
    return sat((9 * (luma[n-4] + luma[n-2]) + 16 * luma[n-3] - luma[n-6]
      - luma[n]) >>> 5);
  endfunction
  // Window row 0 is two lines up; taps run on across line ends
  function automatic int a(int n, int r, int c);
    return luma[n - (2 - r) * W - (2 - c)];
  endfunction
  function automatic int g(int v, int k);
    int c;
    c = (eg >> (3 * k)) & 7;
    return (c >= 1 && c <= 4) ? v << (c - 1) : 0;
  endfunction
  function automatic int edm(int n);
    int s [4];
    int e;
    s[0] = a(n,0,0)+2*a(n,0,1)+a(n,0,2)-a(n,2,0)-2*a(n,2,1)-a(n,2,2);
    s[1] = a(n,0,0)+2*a(n,1,0)+a(n,2,0)-a(n,0,2)-2*a(n,1,2)-a(n,2,2);
    // Diagonal 2 falls toward lower right, diagonal 3 toward lower left
    s[2] = a(n,0,1)+2*a(n,0,0)+a(n,1,0)-a(n,1,2)-2*a(n,2,2)-a(n,2,1);
    s[3] = a(n,0,1)+2*a(n,0,2)+a(n,1,2)-a(n,1,0)-2*a(n,2,0)-a(n,2,1);
    e = 0;
    foreach (s[k]) e += g(s[k] < 0 ? -s[k] : s[k], k);
    return e > 255 ? 255 : e;
  endfunction
  // Negedge sampling: registered results are settled by then
  always @(negedge clk_sys) begin
    if (res_valid === 1'b1) begin
      if (no >= 6) begin
        chk(lf_out, lfm(no));
        chk(hf_out, sat((luma[no-3] - lfm(no)) <<< hs));
        chk(chroma_ok, flg[no-3]);
        if (flg[no-3]) chk(chroma_out, chr[no-3]);
        chk(motion_out, mot[no-3]);
      end
      // Line buffer is stale until two lines have passed
      if (no >= 2 * W + 2) chk(edge_out, edm(no));
      no++;
    end
  end
  task automatic line();
    for (int i = 0; i < W; i++) begin
      @(posedge clk_sys);
      luma[np] = (np * 37 + np / W * 53) & 255;
      chr[np] = (np * 11 + 5) & 255;
      mot[np] = use_motion ? (np * 3) & 255 : 0;
      flg[np] = cf;
      user_active <= 1'b1;
      user_luma <= 8'(luma[np]);
      user_chroma <= 8'(chr[np]);
      user_motion <= 8'(np * 3);
      np++;
    end
    @(posedge clk_sys);
    user_active <= 1'b0;
    repeat (4) @(posedge clk_sys);
    lines++;
    if (fmt_420) cf = !cf;
  endtask
  task automatic tally_and_finish();
    chk(no, np);
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(YFE_REG_HF_GAIN, 32'h0);
    rd(YFE_REG_EDGE_GAIN, 32'h249);
    wr(8'h0c, 32'hffff);
    rd(8'h0c, 32'h0);
    rd(YFE_REG_HF_GAIN, 32'h0);
    $display("Test registers done");
    repeat (6) line();
    $display("Test unity frame done");
    for (int i = 0; i < 5; i++) begin
      hs = 2'(i);
      eg = EGT[i];
      fmt_420 <= !i[0];
      use_motion <= (i != 4);
      if (i[0]) cf = 1'b1;
      wr(YFE_REG_HF_GAIN, 32'(hs));
      wr(YFE_REG_EDGE_GAIN, 32'(eg));
      rd(YFE_REG_EDGE_GAIN, 32'(eg));
      repeat (3) line();
      $display("Test gain set %0d done", i);
    end
    wr(YFE_REG_STATUS, 32'h1234);
    rd(YFE_REG_STATUS, {16'(lines), 16'(W)});
    tally_and_finish();
  end
  initial begin
    #300000;
    mismatches++;
    tally_and_finish();
  end
endmodule
